//--- common/swd_consts.vh
`ifndef SWD_CONSTS_VH
`define SWD_CONSTS_VH

// Clock
`define SWD_CLK_MHZ        125

// Register byte offsets
`define SWD_OFF_CTRL       6'h00
`define SWD_OFF_WDPER      6'h04
`define SWD_OFF_RSTPER     6'h08
`define SWD_OFF_STATE      6'h0C
`define SWD_OFF_ISTS       6'h10
`define SWD_OFF_ICLR       6'h14
`define SWD_OFF_IEN        6'h18
`define SWD_OFF_COUNT      6'h1C
`define SWD_OFF_FAULTS     6'h20

// Control fields
`define SWD_CTRL_W         4
`define SWD_CTRL_RST       4'h0
`define SWD_CTRL_WIN       0
`define SWD_CTRL_EXT       1
`define SWD_CTRL_RSA       2
`define SWD_CTRL_RSB       3

// Widths
`define SWD_PER_W          24
`define SWD_CNT_W          31
`define SWD_FLT_W          8

// Timing
`define SWD_EXT_SHIFT      7
`define SWD_SHIFT_R8       3'h3
`define SWD_SHIFT_R16      3'h4
`define SWD_SHIFT_R64      3'h6
`define SWD_WDPER_DEF      24'h0F4240
`define SWD_RSTPER_DEF     24'h030D40

// Interrupt bits
`define SWD_IRQ_W          4
`define SWD_IRQ_TMO        0
`define SWD_IRQ_FAST       1
`define SWD_IRQ_SLOW       2
`define SWD_IRQ_RPEND      3

`endif

//--- verilog/swd_sync.v
`timescale 1ns/1ps
module swd_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clk,
	input  wire             arst_n,
	// Data
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= din[i];
					sync_q <= meta_q;
				end
			end
			assign dout[i] = sync_q;
		end
	endgenerate
endmodule

//--- verilog/swd_pulse_timer.v
`timescale 1ns/1ps
`include "swd_consts.vh"
module swd_pulse_timer (
	// Clock and reset
	input  wire                  clk,
	input  wire                  arst_n,
	// Control
	input  wire                  start,
	input  wire [`SWD_PER_W-1:0] len,
	// Status
	output reg                   active_q,
	output reg                   rst_n_q,
	output reg                   done_q
);
	reg [`SWD_PER_W-1:0] cnt_q;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q    <= {`SWD_PER_W{1'b0}};
			active_q <= 1'b0;
			rst_n_q  <= 1'b1;
			done_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!active_q) begin
				if (start) begin
					// Zero length still gives one cycle of reset
					cnt_q    <= (len == {`SWD_PER_W{1'b0}}) ? len : len - 1'b1;
					active_q <= 1'b1;
					rst_n_q  <= 1'b0;
				end
			end else if (cnt_q == {`SWD_PER_W{1'b0}}) begin
				active_q <= 1'b0;
				rst_n_q  <= 1'b1;
				done_q   <= 1'b1;
			end else begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

//--- verilog/swd_top.v
`timescale 1ns/1ps
`include "swd_consts.vh"
module swd_top #(
	parameter [`SWD_PER_W-1:0] WDOG_CYC_DEF  = `SWD_WDPER_DEF,
	parameter [`SWD_PER_W-1:0] RESET_CYC_DEF = `SWD_RSTPER_DEF
) (
	// Clock and reset
	input  wire        clk,
	input  wire        arst_n,
	// Avalon-MM slave
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Watchdog pins
	input  wire        wdog_kick_in,
	output wire        wdog_rst_n,
	// Interrupt
	output reg         irq
);
	// Software registers
	reg [`SWD_CTRL_W-1:0] ctrl_q;
	reg [`SWD_CTRL_W-1:0] ctrl_prev_q;
	reg [`SWD_PER_W-1:0]  wdog_period_set_q;
	reg [`SWD_PER_W-1:0]  reset_period_set_q;
	reg [`SWD_IRQ_W-1:0]  irq_sts_q;
	reg [`SWD_IRQ_W-1:0]  irq_sts_d;
	reg [`SWD_IRQ_W-1:0]  irq_en_q;
	reg [`SWD_IRQ_W-1:0]  irq_en_d;
	reg [`SWD_FLT_W-1:0]  fault_cnt_q;

	// Watchdog state
	reg [`SWD_CNT_W-1:0]  cnt_q;
	reg [`SWD_CNT_W-1:0]  cnt_d;
	reg                   kick_prev_q;

	wire                  kick_s;
	wire                  rst_active;
	wire                  rp_done;

	// Bus decode
	wire                  wr_acc;
	wire                  rd_acc;
	reg  [31:0]           rd_mux;

	// Mode decode
	wire                  mode_win;
	wire                  ext_sel;
	wire                  ratio_sel_a;
	wire                  ratio_sel_b;
	wire                  per_zero;
	wire                  std_en;
	wire                  win_en;
	wire                  cfg_chg;
	reg  [2:0]            ratio_shift;

	// Limits and events
	wire [`SWD_CNT_W-1:0] lim_std;
	wire [`SWD_CNT_W-1:0] lim_slow;
	wire [`SWD_CNT_W-1:0] lim_fast;
	wire [`SWD_CNT_W-1:0] cnt_inc;
	wire                  kick_fall;
	wire                  live;
	wire                  ev_tmo;
	wire                  ev_fast;
	wire                  ev_slow;
	wire                  ev_valid;
	wire                  fault;
	wire [`SWD_IRQ_W-1:0] events;

	swd_sync #(
		.WIDTH(1)
	) u_kick_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (wdog_kick_in),
		.dout   (kick_s)
	);

	swd_pulse_timer u_rst_pulse (
		.clk      (clk),
		.arst_n   (arst_n),
		.start    (fault),
		.len      (reset_period_set_q),
		.active_q (rst_active),
		.rst_n_q  (wdog_rst_n),
		.done_q   (rp_done)
	);

	// One wait state: data latched while waitrequest is high, taken after it drops
	assign wr_acc = avs_write & ~avs_waitrequest;
	assign rd_acc = avs_read & avs_waitrequest;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			kick_prev_q <= 1'b0;
		end else begin
			kick_prev_q <= kick_s;
		end
	end

	// Exactly one cycle per falling edge
	assign kick_fall = kick_prev_q & ~kick_s;

	assign mode_win    = ctrl_q[`SWD_CTRL_WIN];
	assign ext_sel     = ctrl_q[`SWD_CTRL_EXT];
	assign ratio_sel_a = ctrl_q[`SWD_CTRL_RSA];
	assign ratio_sel_b = ctrl_q[`SWD_CTRL_RSB];
	assign per_zero    = (wdog_period_set_q == {`SWD_PER_W{1'b0}});

	assign std_en = ~mode_win & ~per_zero;
	assign win_en = mode_win & ~per_zero & ~(ratio_sel_a & ~ratio_sel_b);

	// Any select change restarts the interval so a mode switch never faults
	assign cfg_chg = (ctrl_q != ctrl_prev_q);

	always @* begin
		case ({ratio_sel_a, ratio_sel_b})
			2'b00: ratio_shift = `SWD_SHIFT_R8;
			2'b01: ratio_shift = `SWD_SHIFT_R16;
			2'b11: ratio_shift = `SWD_SHIFT_R64;
			default: ratio_shift = `SWD_SHIFT_R8;
		endcase
	end

	assign lim_std = ext_sel ?
		{wdog_period_set_q, {`SWD_EXT_SHIFT{1'b0}}} :
		{{`SWD_EXT_SHIFT{1'b0}}, wdog_period_set_q};
	assign lim_slow = {{`SWD_EXT_SHIFT{1'b0}}, wdog_period_set_q};
	assign lim_fast = lim_slow >> ratio_shift;
	assign cnt_inc  = cnt_q + 1'b1;

	// Nothing counts or faults while the reset pulse runs
	assign live = ~rst_active & ~cfg_chg;

	assign ev_tmo   = std_en & live & ~kick_fall & (cnt_inc >= lim_std);
	assign ev_fast  = win_en & live & kick_fall & (cnt_q < lim_fast);
	assign ev_slow  = win_en & live & ~kick_fall & (cnt_inc >= lim_slow);
	assign ev_valid = win_en & live & kick_fall & (cnt_q >= lim_fast);
	assign fault    = ev_tmo | ev_fast | ev_slow;

	always @* begin
		cnt_d = cnt_q;
		if (rst_active) begin
			cnt_d = {`SWD_CNT_W{1'b0}};
		end else if (cfg_chg) begin
			cnt_d = {`SWD_CNT_W{1'b0}};
		end else if (fault) begin
			cnt_d = {`SWD_CNT_W{1'b0}};
		end else if (std_en) begin
			if (kick_fall) begin
				cnt_d = {`SWD_CNT_W{1'b0}};
			end else begin
				cnt_d = cnt_inc;
			end
		end else if (win_en) begin
			if (ev_valid) begin
				cnt_d = {`SWD_CNT_W{1'b0}};
			end else begin
				cnt_d = cnt_inc;
			end
		end else begin
			cnt_d = {`SWD_CNT_W{1'b0}};
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= {`SWD_CNT_W{1'b0}};
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Interrupt sources
	assign events = {rp_done, ev_slow, ev_fast, ev_tmo};

	always @* begin
		irq_en_d  = irq_en_q;
		irq_sts_d = irq_sts_q;
		if (wr_acc && avs_address == `SWD_OFF_IEN) begin
			irq_en_d = avs_writedata[`SWD_IRQ_W-1:0];
		end
		if (wr_acc && avs_address == `SWD_OFF_ICLR) begin
			irq_sts_d = irq_sts_q & ~avs_writedata[`SWD_IRQ_W-1:0];
		end
		// A new event outranks a clear in the same cycle
		irq_sts_d = irq_sts_d | events;
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_sts_q <= {`SWD_IRQ_W{1'b0}};
			irq_en_q  <= {`SWD_IRQ_W{1'b0}};
			irq       <= 1'b0;
		end else begin
			irq_sts_q <= irq_sts_d;
			irq_en_q  <= irq_en_d;
			irq       <= |(irq_sts_d & irq_en_d);
		end
	end

	// Configuration registers
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q             <= `SWD_CTRL_RST;
			ctrl_prev_q        <= `SWD_CTRL_RST;
			wdog_period_set_q  <= WDOG_CYC_DEF;
			reset_period_set_q <= RESET_CYC_DEF;
		end else begin
			ctrl_prev_q <= ctrl_q;
			if (wr_acc) begin
				case (avs_address)
					`SWD_OFF_CTRL: begin
						ctrl_q <= avs_writedata[`SWD_CTRL_W-1:0];
					end
					`SWD_OFF_WDPER: begin
						wdog_period_set_q <= avs_writedata[`SWD_PER_W-1:0];
					end
					`SWD_OFF_RSTPER: begin
						reset_period_set_q <= avs_writedata[`SWD_PER_W-1:0];
					end
					default: begin
						ctrl_q <= ctrl_q;
					end
				endcase
			end
		end
	end

	// Fault counter saturates so software sees a storm, not a wrap
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_cnt_q <= {`SWD_FLT_W{1'b0}};
		end else if (fault && fault_cnt_q != {`SWD_FLT_W{1'b1}}) begin
			fault_cnt_q <= fault_cnt_q + 1'b1;
		end
	end

	// Read mux; unmapped and write-only offsets read as zero
	always @* begin
		rd_mux = 32'h00000000;
		case (avs_address)
			`SWD_OFF_CTRL: begin
				rd_mux[`SWD_CTRL_W-1:0] = ctrl_q;
			end
			`SWD_OFF_WDPER: begin
				rd_mux[`SWD_PER_W-1:0] = wdog_period_set_q;
			end
			`SWD_OFF_RSTPER: begin
				rd_mux[`SWD_PER_W-1:0] = reset_period_set_q;
			end
			`SWD_OFF_STATE: begin
				rd_mux[3:0] = {kick_s, win_en, std_en, rst_active};
			end
			`SWD_OFF_ISTS: begin
				rd_mux[`SWD_IRQ_W-1:0] = irq_sts_q;
			end
			`SWD_OFF_IEN: begin
				rd_mux[`SWD_IRQ_W-1:0] = irq_en_q;
			end
			`SWD_OFF_COUNT: begin
				rd_mux[`SWD_CNT_W-1:0] = cnt_q;
			end
			`SWD_OFF_FAULTS: begin
				rd_mux[`SWD_FLT_W-1:0] = fault_cnt_q;
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	// Bus handshake: one wait cycle per access, then a fresh request
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			if (!avs_waitrequest) begin
				avs_waitrequest <= 1'b1;
			end else if (avs_read || avs_write) begin
				avs_waitrequest <= 1'b0;
			end
			if (rd_acc) begin
				avs_readdata <= rd_mux;
			end
		end
	end
endmodule

//--- verif/swd_kick_model.sv
`timescale 1ns/1ps
module swd_kick_model (
	// Clock
	input  wire        clk,
	// Control from the bench
	input  wire        en,
	input  wire [7:0]  period,
	// Kick pin
	output logic       kick
);
	logic [7:0] cnt_q;

	initial begin
		kick  = 1'b1;
		cnt_q = 8'h00;
	end

	// Two low cycles per kick so the synchroniser always sees it
	always @(posedge clk) begin
		if (!en || cnt_q == period - 8'h01)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + 8'h01;
		kick <= !(en && cnt_q >= period - 8'h02);
	end
endmodule

//--- verif/swd_top_chk.sv
`timescale 1ns/1ps
`include "swd_consts.vh"
module swd_top_chk #(
	parameter [`SWD_PER_W-1:0] WDOG_CYC_DEF  = `SWD_WDPER_DEF,
	parameter [`SWD_PER_W-1:0] RESET_CYC_DEF = `SWD_RSTPER_DEF
) (
	// Clock and reset
	input wire        clk,
	input wire        arst_n,
	// Register bus
	input wire [5:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// Watchdog pins and interrupt
	input wire        wdog_kick_in,
	input wire        wdog_rst_n,
	input wire        irq
);
	logic [`SWD_PER_W-1:0] lo_q;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			lo_q <= '0;
		else if (wdog_rst_n)
			lo_q <= '0;
		else
			lo_q <= lo_q + 1'b1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_taken;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_rd;
		avs_read && avs_waitrequest;
	endsequence

	chk_wait_answer: assert property (s_taken |=> !avs_waitrequest)
		else $error("waitrequest did not drop");
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest dropped while idle");
	chk_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	chk_rd_zero: assert property (s_rd ##0 (avs_address == `SWD_OFF_ICLR
		|| avs_address > 6'h23) |=> avs_readdata == 32'h0)
		else $error("write-only or unmapped read not zero");
	chk_ctrl_upper: assert property (s_rd ##0 avs_address == `SWD_OFF_CTRL
		|=> avs_readdata[31:`SWD_CTRL_W] == '0)
		else $error("control upper bits not zero");
	chk_pulse_len: assert property ($rose(wdog_rst_n) |-> lo_q == RESET_CYC_DEF)
		else $error("reset pulse length wrong");
	chk_irq_fall: assert property ($fell(irq) |-> $past(avs_write))
		else $error("irq fell without a write");
endmodule

//--- verif/test_swd_top.sv
`timescale 1ns/1ps
`include "swd_consts.vh"
module test_swd_top;
	logic        clk;
	logic        arst_n;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire         wdog_kick_in;
	wire         wdog_rst_n;
	wire         irq;
	logic        kick_en;
	logic [7:0]  kick_per;
	logic [31:0] rd;
	int          miscompares;
	int          n_checks;

	// Short periods: 64 cycle watchdog, 8 cycle reset pulse
	swd_top #(.WDOG_CYC_DEF(24'h000040), .RESET_CYC_DEF(24'h000008)) u_dut (
		.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .wdog_kick_in(wdog_kick_in),
		.wdog_rst_n(wdog_rst_n), .irq(irq));
	swd_kick_model u_kick (.clk(clk), .en(kick_en), .period(kick_per), .kick(wdog_kick_in));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= ~w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic fault_in(input int lo, input int hi);
		int n;
		int len;
		n = 0;
		len = 0;
		while (wdog_rst_n !== 1'b0 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		chk(n >= lo && n <= hi, 1);
		while (wdog_rst_n === 1'b0 && len < 99) begin
			@(posedge clk);
			len++;
		end
		chk(len, 8);
	endtask

	// Registers, status and interrupt after the first timeout
	task automatic test_regs;
		bus(1'b0, `SWD_OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, `SWD_OFF_WDPER, 32'h0);
		chk(rd, 32'h40);
		bus(1'b0, `SWD_OFF_RSTPER, 32'h0);
		chk(rd, 32'h8);
		bus(1'b0, `SWD_OFF_STATE, 32'h0);
		chk(rd, 32'hA);
		bus(1'b0, `SWD_OFF_FAULTS, 32'h0);
		chk(rd, 32'h1);
		bus(1'b0, 6'h24, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, `SWD_OFF_ISTS, 32'h0);
		chk(rd, 32'h9);
		#1 chk(irq, 1'b0);
		bus(1'b1, `SWD_OFF_IEN, 32'h1);
		#1 chk(irq, 1'b1);
		bus(1'b1, `SWD_OFF_ICLR, 32'hF);
		#1 chk(irq, 1'b0);
		bus(1'b0, `SWD_OFF_ISTS, 32'h0);
		chk(rd, 32'h0);
	endtask

	// Kicks stop afterwards and the pulse is let run out
	task automatic obs(input logic [31:0] ctrl, input logic [7:0] per, input logic exp);
		logic f;
		f = 1'b0;
		bus(1'b1, `SWD_OFF_CTRL, ctrl);
		kick_per <= per;
		kick_en  <= per != 8'h00;
		repeat (300) begin
			@(posedge clk);
			if (wdog_rst_n === 1'b0)
				f = 1'b1;
		end
		chk(f, exp);
		kick_en <= 1'b0;
		repeat (30) @(posedge clk);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		test_done;
	end

	initial begin
		arst_n        = 1'b0;
		avs_address   = 6'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		kick_en       = 1'b0;
		kick_per      = 8'h00;
		miscompares   = 0;
		n_checks      = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		fault_in(62, 68);
		test_regs;
		bus(1'b1, `SWD_OFF_CTRL, 32'h2);
		fault_in(8190, 8198);
		bus(1'b1, `SWD_OFF_CTRL, 32'h0);
		fault_in(62, 68);
		obs(32'h0, 8'd40, 1'b0);
		bus(1'b1, `SWD_OFF_WDPER, 32'h0);
		obs(32'h0, 8'd0, 1'b0);
		bus(1'b1, `SWD_OFF_WDPER, 32'h80);
		obs(32'h1, 8'd12, 1'b1);
		obs(32'h9, 8'd12, 1'b0);
		obs(32'h9, 8'd6, 1'b1);
		obs(32'hD, 8'd6, 1'b0);
		obs(32'h5, 8'd6, 1'b0);
		obs(32'h5, 8'd0, 1'b0);
		obs(32'h1, 8'd0, 1'b1);
		test_done;
	end
endmodule

bind swd_top swd_top_chk #(.WDOG_CYC_DEF(WDOG_CYC_DEF), .RESET_CYC_DEF(RESET_CYC_DEF)) u_chk (
	.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .wdog_kick_in(wdog_kick_in),
	.wdog_rst_n(wdog_rst_n), .irq(irq));
